// ===== hw/sse_pkg.sv
// Constants and types for the skip-and-set instruction execution block
package sse_pkg;
    localparam int SSE_DW = 8;
    localparam int SSE_BW = 3;
    localparam logic [SSE_DW-1:0] SSE_ONE = 8'h01;
    localparam logic [SSE_DW-1:0] SSE_ZERO = 8'h00;
    localparam logic [SSE_DW-1:0] SSE_ALL_ONES = 8'hff;
    localparam logic [SSE_DW-1:0] SSE_ACC_RESET = 8'h00;
    localparam logic [5:0] SSE_FLAGS_RESET = 6'h00;

    typedef enum logic [2:0] {
        SSE_OP_NONE = 3'b000,
        SSE_OP_DEC_SKIP_ZERO_MEM = 3'b001,
        SSE_OP_DEC_SKIP_ZERO_TO_ACC = 3'b010,
        SSE_OP_INC_SKIP_ZERO_MEM = 3'b011,
        SSE_OP_SET_BYTE = 3'b100,
        SSE_OP_SET_BIT = 3'b101
    } sse_op_t;

    typedef enum logic [0:0] {
        SSE_ST_EXEC = 1'b0,
        SSE_ST_DUMMY = 1'b1
    } sse_state_t;
endpackage

// ===== hw/sse_alu.sv
// Combinational result and skip decision for the skip-and-set instructions
`timescale 1ns/1ps
`default_nettype none
module sse_alu
    import sse_pkg::*;
#(
    parameter int DW = SSE_DW,
    parameter int BW = SSE_BW
) (
    input wire sse_op_t op,
    input wire logic [DW-1:0] operand,
    input wire logic [BW-1:0] bit_sel,
    output logic [DW-1:0] result,
    output logic mem_we,
    output logic acc_we,
    output logic skip
);
    always_comb begin
        result = operand;
        mem_we = 1'b0;
        acc_we = 1'b0;
        skip = 1'b0;
        unique case (op)
            SSE_OP_DEC_SKIP_ZERO_MEM: begin
                result = operand - DW'(SSE_ONE);
                mem_we = 1'b1;
                skip = (result == DW'(SSE_ZERO));
            end
            SSE_OP_DEC_SKIP_ZERO_TO_ACC: begin
                result = operand - DW'(SSE_ONE);
                acc_we = 1'b1;
                skip = (result == DW'(SSE_ZERO));
            end
            SSE_OP_INC_SKIP_ZERO_MEM: begin
                result = operand + DW'(SSE_ONE);
                mem_we = 1'b1;
                skip = (result == DW'(SSE_ZERO));
            end
            SSE_OP_SET_BYTE: begin
                result = DW'(SSE_ALL_ONES);
                mem_we = 1'b1;
            end
            SSE_OP_SET_BIT: begin
                result = operand | (DW'(SSE_ONE) << bit_sel);
                mem_we = 1'b1;
            end
            default: begin
                result = operand;
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== hw/sse_exec.sv
// Execution stage for decrement/increment-skip and set instructions
`timescale 1ns/1ps
`default_nettype none
module sse_exec
    import sse_pkg::*;
#(
    parameter int DW = SSE_DW,
    parameter int BW = SSE_BW
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire sse_op_t instr_op,
    input wire logic [BW-1:0] instr_bit,
    input wire logic [DW-1:0] mem_rdata,
    input wire logic [5:0] flags_in,
    output logic instr_ready,
    output logic [DW-1:0] mem_wdata,
    output logic mem_wr,
    output logic [DW-1:0] acc,
    output logic [5:0] flags_out,
    output logic discard_prefetch,
    output logic dummy_cycle,
    output logic instr_done
);
    ////////////////////////////////////////////////////////////////////////
    sse_state_t state;
    sse_state_t next_state;
    logic [DW-1:0] alu_result;
    logic alu_mem_we;
    logic alu_acc_we;
    logic alu_skip;
    logic take;
    logic [DW-1:0] next_acc;
    logic [DW-1:0] next_mem_wdata;
    logic next_mem_wr;
    logic [5:0] next_flags;
    logic next_discard;
    logic next_done;

    sse_alu #(.DW(DW), .BW(BW)) u_alu (
        .op(instr_op),
        .operand(mem_rdata),
        .bit_sel(instr_bit),
        .result(alu_result),
        .mem_we(alu_mem_we),
        .acc_we(alu_acc_we),
        .skip(alu_skip)
    );

    ////////////////////////////////////////////////////////////////////////
    // A new instruction is accepted only outside the dummy cycle
    assign instr_ready = (state == SSE_ST_EXEC);
    assign dummy_cycle = (state == SSE_ST_DUMMY);
    assign take = instr_valid && instr_ready;

    always_comb begin
        next_state = state;
        next_acc = acc;
        next_mem_wdata = mem_wdata;
        next_mem_wr = 1'b0;
        next_flags = flags_in;
        next_discard = 1'b0;
        next_done = 1'b0;
        unique case (state)
            SSE_ST_EXEC: begin
                if (take) begin
                    next_mem_wdata = alu_result;
                    next_mem_wr = alu_mem_we;
                    if (alu_acc_we) begin
                        next_acc = alu_result;
                    end
                    if (alu_skip) begin
                        next_discard = 1'b1;
                        next_state = SSE_ST_DUMMY;
                    end else begin
                        next_done = 1'b1;
                    end
                end
            end
            SSE_ST_DUMMY: begin
                next_done = 1'b1;
                next_state = SSE_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= SSE_ST_EXEC;
            acc <= DW'(SSE_ACC_RESET);
            mem_wdata <= DW'(SSE_ZERO);
            mem_wr <= 1'b0;
            flags_out <= SSE_FLAGS_RESET;
            discard_prefetch <= 1'b0;
            instr_done <= 1'b0;
        end else begin
            state <= next_state;
            acc <= next_acc;
            mem_wdata <= next_mem_wdata;
            mem_wr <= next_mem_wr;
            flags_out <= next_flags;
            discard_prefetch <= next_discard;
            instr_done <= next_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_dec_mem;
        @(posedge core_clk) disable iff (!rstn)
        take && instr_op == SSE_OP_DEC_SKIP_ZERO_MEM |=>
            mem_wr && mem_wdata == DW'($past(mem_rdata) - DW'(SSE_ONE));
    endproperty
    a_dec_mem: assert property (p_dec_mem) else $error("decrement write wrong");

    property p_skip_two;
        @(posedge core_clk) disable iff (!rstn)
        take && alu_skip |=> discard_prefetch && !instr_done && !instr_ready ##1 instr_done;
    endproperty
    a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");

    property p_noskip_one;
        @(posedge core_clk) disable iff (!rstn)
        take && !alu_skip |=> instr_done && !discard_prefetch && instr_ready;
    endproperty
    a_noskip_one: assert property (p_noskip_one) else $error("no-skip not one cycle");

    property p_dec_acc;
        @(posedge core_clk) disable iff (!rstn)
        take && instr_op == SSE_OP_DEC_SKIP_ZERO_TO_ACC |=>
            !mem_wr && acc == DW'($past(mem_rdata) - DW'(SSE_ONE));
    endproperty
    a_dec_acc: assert property (p_dec_acc) else $error("acc decrement wrong");

    property p_set_byte;
        @(posedge core_clk) disable iff (!rstn)
        take && instr_op == SSE_OP_SET_BYTE |=> mem_wr && mem_wdata == DW'(SSE_ALL_ONES);
    endproperty
    a_set_byte: assert property (p_set_byte) else $error("byte set wrong");

    property p_set_bit;
        @(posedge core_clk) disable iff (!rstn)
        take && instr_op == SSE_OP_SET_BIT |=> mem_wr && mem_wdata[$past(instr_bit)]
            && ((mem_wdata ^ $past(mem_rdata)) & ~(DW'(SSE_ONE) << $past(instr_bit)))
            == DW'(SSE_ZERO);
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("bit set wrong");

    property p_inc_mem;
        @(posedge core_clk) disable iff (!rstn)
        take && instr_op == SSE_OP_INC_SKIP_ZERO_MEM |=>
            mem_wr && mem_wdata == DW'($past(mem_rdata) + DW'(SSE_ONE))
            && (discard_prefetch == (mem_wdata == DW'(SSE_ZERO)));
    endproperty
    a_inc_mem: assert property (p_inc_mem) else $error("increment wrong");

    property p_flags;
        @(posedge core_clk) disable iff (!rstn)
        ##1 flags_out == $past(flags_in);
    endproperty
    a_flags: assert property (p_flags) else $error("flags altered");

    ////////////////////////////////////////////////////////////////////////
    // Handshake and dummy-cycle bookkeeping
    property p_ready_dummy;
        @(posedge core_clk) disable iff (!rstn)
        instr_ready != dummy_cycle;
    endproperty
    a_ready_dummy: assert property (p_ready_dummy) else $error("ready during dummy");

    property p_discard_dummy;
        @(posedge core_clk) disable iff (!rstn)
        discard_prefetch == dummy_cycle;
    endproperty
    a_discard_dummy: assert property (p_discard_dummy) else $error("discard off dummy");

    property p_dummy_once;
        @(posedge core_clk) disable iff (!rstn)
        dummy_cycle |=> !dummy_cycle && instr_done && !mem_wr;
    endproperty
    a_dummy_once: assert property (p_dummy_once) else $error("dummy cycle repeated");

    property p_idle_quiet;
        @(posedge core_clk) disable iff (!rstn)
        !take && !dummy_cycle |=> !mem_wr && !instr_done && !discard_prefetch;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle");

    ////////////////////////////////////////////////////////////////////////
    // Result-dependent skip decisions and accumulator hold
    property p_dec_skip;
        @(posedge core_clk) disable iff (!rstn)
        take && instr_op == SSE_OP_DEC_SKIP_ZERO_MEM |=>
            discard_prefetch == (mem_wdata == DW'(SSE_ZERO));
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");

    property p_acc_skip;
        @(posedge core_clk) disable iff (!rstn)
        take && instr_op == SSE_OP_DEC_SKIP_ZERO_TO_ACC |=>
            discard_prefetch == (acc == DW'(SSE_ZERO));
    endproperty
    a_acc_skip: assert property (p_acc_skip) else $error("acc skip wrong");

    property p_acc_hold;
        @(posedge core_clk) disable iff (!rstn)
        take && instr_op != SSE_OP_DEC_SKIP_ZERO_TO_ACC |=> acc == $past(acc);
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("acc changed");

    // Set instructions never skip
    property p_set_noskip;
        @(posedge core_clk) disable iff (!rstn)
        take && (instr_op == SSE_OP_SET_BYTE || instr_op == SSE_OP_SET_BIT) |=>
            !discard_prefetch && instr_done;
    endproperty
    a_set_noskip: assert property (p_set_noskip) else $error("set skipped");
endmodule
`default_nettype wire

// ===== verification/sse_exec_test.sv
// Self-checking testbench for the skip-and-set execution block
`timescale 1ns/1ps
`default_nettype none
module sse_exec_test;
    import sse_pkg::*;
    logic core_clk, rstn, instr_valid;
    sse_op_t instr_op;
    logic [2:0] instr_bit;
    logic [7:0] mem_rdata, mem_wdata, acc, exp_acc;
    logic [5:0] flags_in, flags_out;
    logic instr_ready, mem_wr, discard_prefetch, dummy_cycle, instr_done;
    int n_fail, n_tests;
    sse_exec u_sse_exec (.core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_bit(instr_bit), .mem_rdata(mem_rdata),
        .flags_in(flags_in), .instr_ready(instr_ready), .mem_wdata(mem_wdata),
        .mem_wr(mem_wr), .acc(acc), .flags_out(flags_out),
        .discard_prefetch(discard_prefetch), .dummy_cycle(dummy_cycle),
        .instr_done(instr_done));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("fails=%0d tests=%0d", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One instruction; while a skip's dummy cycle runs, a set-byte is offered and must be refused
    task automatic exec(input sse_op_t op, input logic [7:0] rd, input logic [2:0] b,
            input logic [7:0] res, input logic wr, input logic sk);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_bit <= b;
        mem_rdata <= rd;
        flags_in <= rd[5:0] ^ 6'h2a;
        @(posedge core_clk);
        instr_valid <= sk;
        instr_op <= SSE_OP_SET_BYTE;
        #1;
        if (op == SSE_OP_DEC_SKIP_ZERO_TO_ACC) exp_acc = res;
        check(8'(mem_wr), 8'(wr));
        if (wr) check(mem_wdata, res);
        check(acc, exp_acc);
        check(8'(flags_out), 8'(rd[5:0] ^ 6'h2a));
        check(8'(discard_prefetch), 8'(sk));
        check(8'(dummy_cycle), 8'(sk));
        check(8'(instr_done), 8'(!sk));
        check(8'(instr_ready), 8'(!sk));
        if (sk) begin
            @(posedge core_clk);
            instr_valid <= 1'b0;
            #1;
            check(8'(instr_done), 8'h01);
            check(8'(instr_ready), 8'h01);
            check(8'(mem_wr), 8'h00);
            check(8'(discard_prefetch), 8'h00);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_dec_mem();
        exec(SSE_OP_DEC_SKIP_ZERO_MEM, 8'h01, 3'h0, 8'h00, 1'b1, 1'b1);
        exec(SSE_OP_DEC_SKIP_ZERO_MEM, 8'h05, 3'h0, 8'h04, 1'b1, 1'b0);
        exec(SSE_OP_DEC_SKIP_ZERO_MEM, 8'h00, 3'h0, 8'hff, 1'b1, 1'b0);
    endtask
    task automatic t_dec_acc();
        exec(SSE_OP_DEC_SKIP_ZERO_TO_ACC, 8'h80, 3'h0, 8'h7f, 1'b0, 1'b0);
        exec(SSE_OP_DEC_SKIP_ZERO_TO_ACC, 8'h01, 3'h0, 8'h00, 1'b0, 1'b1);
        exec(SSE_OP_DEC_SKIP_ZERO_TO_ACC, 8'h00, 3'h0, 8'hff, 1'b0, 1'b0);
    endtask
    task automatic t_inc_mem();
        exec(SSE_OP_INC_SKIP_ZERO_MEM, 8'hff, 3'h0, 8'h00, 1'b1, 1'b1);
        exec(SSE_OP_INC_SKIP_ZERO_MEM, 8'h7f, 3'h0, 8'h80, 1'b1, 1'b0);
    endtask
    task automatic t_set();
        exec(SSE_OP_SET_BYTE, 8'h5a, 3'h0, 8'hff, 1'b1, 1'b0);
        exec(SSE_OP_SET_BYTE, 8'h00, 3'h0, 8'hff, 1'b1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            exec(SSE_OP_SET_BIT, 8'ha0, 3'(i), 8'ha0 | (8'h01 << i), 1'b1, 1'b0);
            exec(SSE_OP_SET_BIT, 8'h00, 3'(i), 8'h01 << i, 1'b1, 1'b0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        n_fail++;
        complete_run();
    end
    initial begin
        n_fail = 0;
        n_tests = 0;
        rstn = 1'b0;
        instr_valid = 1'b0;
        instr_op = SSE_OP_NONE;
        instr_bit = 3'h0;
        mem_rdata = 8'h00;
        flags_in = 6'h00;
        exp_acc = SSE_ACC_RESET;
        repeat (8) @(posedge core_clk);
        #1;
        check(acc, SSE_ACC_RESET);
        check(8'(instr_ready), 8'h01);
        rstn <= 1'b1;
        t_dec_mem();
        t_dec_acc();
        t_inc_mem();
        t_set();
        complete_run();
    end
endmodule
`default_nettype wire
